// ### opmode_pkg.sv
// Constants, field layouts and carrier types of the operating-mode controller.
// Overview of operation
// RULE_01: Leaving shutdown always lands in active mode.
// RULE_02: Shutdown wakes when supply is above 12.5 V and wake is high.
// RULE_03: After wake-up the ready reset output is released low to high.
// RULE_04: After wake-up the host drives the wake input low and keeps it.
// RULE_05: Writing zero to control bit 0 restores all settings to defaults.
// RULE_06: An accepted soft reset drives serial data output low to high.
// RULE_07: With an on-chip logic supply the host soft-resets first.
// RULE_08: Enabled watchdog shuts down after set idle time with wake low.
// RULE_09: Mode reads back as five flags at status bits 4 to 0.
// RULE_10: From active, setting control bit 4 enters standby.
// RULE_11: Standby stops serial traffic; low power keeps it; else alike.
// RULE_12: Serial enable high over 3 ms returns standby to active; the code enters low power instead if control bit 3 is set.
// RULE_13: Control bit 3 set enters low power; clearing it returns to active.
// RULE_14: Reduced modes halt cell and fast current conversion; slow may run.
// RULE_15: Active mode offers voltage, both current conversions, protection.
// RULE_16: Control bits 12 to 11 select intermittent wake from reduced modes; the code only sets intermittent_flag and never wakes.
// RULE_17: Standby and low-power requests together are taken as standby.
package opmode_pkg;

  localparam int CNT_W = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned S_PER_MIN = 60;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned STBY_EXIT_MS = 3;
  localparam int unsigned STBY_EXIT_CYCLES = STBY_EXIT_MS * CYC_PER_MS;
  localparam int unsigned WDT_DEFAULT_MIN = 1;
  localparam int unsigned WDT_DEFAULT_MS =
    WDT_DEFAULT_MIN * S_PER_MIN * MS_PER_S;
  localparam int unsigned WAKE_DONE_CYCLES = 16;
  // Supply threshold that the external comparator flags, in millivolts.
  localparam int unsigned MIN_SUPPLY_MV = 12500;

  localparam logic [ADDR_W-1:0] MODE_CTRL_ADDR = 8'h01;
  localparam logic [ADDR_W-1:0] MODE_STAT_ADDR = 8'h1C;

  localparam int SOFT_RESET_BIT = 0;
  localparam int LP_REQ_BIT = 3;
  localparam int STBY_REQ_BIT = 4;
  localparam int INTM_LSB = 11;
  localparam int INTM_MSB = 12;

  localparam logic [DATA_W-1:0] MODE_CTRL_RESET = 16'h0001;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [1:0] INTM_OFF = 2'h0;
  localparam int STAT_FLAG_W = 5;

  typedef enum logic [2:0] {
    m_shutdown,
    m_waking,
    m_active,
    m_lowpower,
    m_standby
  } op_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  // Bit 0 is active_flag, bit 4 is shutdown_flag.
  typedef struct packed {
    logic shutdown_flag;
    logic intermittent_flag;
    logic standby_flag;
    logic lowpower_flag;
    logic active_flag;
  } mode_flags_s;

  typedef struct packed {
    logic cell_conv_en;
    logic hs_conv_en;
    logic ls_conv_allowed;
    logic protect_en;
  } meas_en_s;

endpackage

// ### opmode_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module opmode_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic level_nxt;

  // A change counts only once the second and third stages agree.
  always_comb begin
    level_nxt = level_r;
    if (s2_r == s3_r) begin
      level_nxt = s3_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      level_r <= RESET_VAL;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign o_level = level_r;

endmodule

// ### opmode_timer.sv
// Clearable up-counter that flags when it has reached its limit.
`timescale 1ns/1ps
module opmode_timer #(
  parameter int W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_en,
  input wire logic [W-1:0] i_limit,
  output logic o_done
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (i_clear) begin
      cnt_nxt = '0;
    end else if (i_en && (cnt_r != i_limit)) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    done_nxt = !i_clear && (cnt_nxt == i_limit);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_done = done_r;

endmodule

// ### operating_mode_controller.sv
// Operating-mode controller: shutdown, wake, active, low power and standby.
`timescale 1ns/1ps
module operating_mode_controller #(
  parameter logic [opmode_pkg::CNT_W-1:0] MS_TICK_CYCLES =
    opmode_pkg::CNT_W'(opmode_pkg::CYC_PER_MS),
  parameter logic [opmode_pkg::CNT_W-1:0] STBY_EXIT_CYC =
    opmode_pkg::CNT_W'(opmode_pkg::STBY_EXIT_CYCLES),
  parameter logic [opmode_pkg::CNT_W-1:0] WDT_LIMIT_MS =
    opmode_pkg::CNT_W'(opmode_pkg::WDT_DEFAULT_MS),
  parameter logic [opmode_pkg::CNT_W-1:0] WAKE_CYCLES =
    opmode_pkg::CNT_W'(opmode_pkg::WAKE_DONE_CYCLES)
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_wake_input,
  input wire logic i_serial_enable_pin,
  input wire logic i_supply_ok,
  input wire logic i_wdt_enable,
  input wire opmode_pkg::reg_req_s i_req,
  output logic [opmode_pkg::DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic o_serial_enabled,
  output logic o_sdo_high,
  output logic o_soft_reset,
  output logic o_ready_reset_output_o,
  output logic o_ready_reset_output_oe,
  output opmode_pkg::mode_flags_s o_flags,
  output opmode_pkg::meas_en_s o_meas
);
  import opmode_pkg::*;

  function automatic mode_flags_s flags_of(input op_mode_e m,
                                           input logic [DATA_W-1:0] c);
    mode_flags_s f;
    f = '0;
    f.active_flag = (m == m_active);
    f.lowpower_flag = (m == m_lowpower);
    f.standby_flag = (m == m_standby);
    f.shutdown_flag = (m == m_shutdown);
    f.intermittent_flag = ((m == m_lowpower) || (m == m_standby)) &&
                          (c[INTM_MSB:INTM_LSB] != INTM_OFF); // RULE_16
    return f;
  endfunction

  function automatic op_mode_e req_mode(input logic [DATA_W-1:0] c);
    op_mode_e m;
    m = m_active;
    if (c[STBY_REQ_BIT]) begin
      m = m_standby; // RULE_10 RULE_17
    end else if (c[LP_REQ_BIT]) begin
      m = m_lowpower; // RULE_13
    end
    return m;
  endfunction

  logic wake_lvl;
  logic sen_lvl;
  logic supply_lvl;
  logic ms_tick;
  logic wake_done;
  logic stby_exit;
  logic wdt_expire;
  logic comm_ok;
  logic acc_wr;
  logic acc_rd;
  logic wdt_clear;
  logic stby_en;

  op_mode_e mode_r;
  op_mode_e mode_nxt;
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] ctrl_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic sdo_r;
  logic sdo_nxt;
  logic soft_r;
  logic soft_nxt;
  logic rst_oe_r;
  logic rst_oe_nxt;
  logic rst_o_r;
  logic ser_en_r;
  logic ser_en_nxt;
  mode_flags_s flags_r;
  mode_flags_s flags_nxt;
  meas_en_s meas_r;
  meas_en_s meas_nxt;

  opmode_sync u_sync_wake (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin(i_wake_input),
    .o_level(wake_lvl)
  );

  opmode_sync u_sync_sen (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin(i_serial_enable_pin),
    .o_level(sen_lvl)
  );

  opmode_sync u_sync_supply (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin(i_supply_ok),
    .o_level(supply_lvl)
  );

  // Free-running millisecond enable for the watchdog.
  opmode_timer #(.W(CNT_W)) u_ms_tick (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clear(ms_tick),
    .i_en(1'b1),
    .i_limit(MS_TICK_CYCLES - 1'b1),
    .o_done(ms_tick)
  );

  opmode_timer #(.W(CNT_W)) u_wake_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clear(mode_r != m_waking),
    .i_en(mode_r == m_waking),
    .i_limit(WAKE_CYCLES),
    .o_done(wake_done)
  );

  // Serial enable must stay high past the exit time; any low restarts it.
  assign stby_en = (mode_r == m_standby) && sen_lvl;
  opmode_timer #(.W(CNT_W)) u_stby_exit (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clear(!stby_en),
    .i_en(stby_en),
    .i_limit(STBY_EXIT_CYC + 1'b1),
    .o_done(stby_exit)
  ); // RULE_12

  // Idle time runs only while enabled, awake and the wake input is low.
  assign wdt_clear = !i_wdt_enable || wake_lvl || acc_wr || acc_rd ||
                     (mode_r == m_shutdown) || (mode_r == m_waking);
  opmode_timer #(.W(CNT_W)) u_watchdog (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clear(wdt_clear),
    .i_en(ms_tick),
    .i_limit(WDT_LIMIT_MS),
    .o_done(wdt_expire)
  ); // RULE_08

  // Register traffic is accepted only while the serial link is kept alive.
  assign comm_ok = (mode_r == m_active) || (mode_r == m_lowpower); // RULE_11
  assign acc_wr = i_req.wr && comm_ok;
  assign acc_rd = i_req.rd && comm_ok && !i_req.wr;

  always_comb begin
    mode_nxt = mode_r;
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    sdo_nxt = sdo_r;
    soft_nxt = 1'b0;
    if (acc_rd) begin
      rvalid_nxt = 1'b1;
      if (i_req.addr == MODE_CTRL_ADDR) begin
        rdata_nxt = ctrl_r;
      end else if (i_req.addr == MODE_STAT_ADDR) begin
        rdata_nxt = {{(DATA_W - STAT_FLAG_W){1'b0}}, flags_r}; // RULE_09
      end else begin
        rdata_nxt = ZERO_WORD;
      end
    end
    case (mode_r)
      m_shutdown: begin
        ctrl_nxt = MODE_CTRL_RESET;
        sdo_nxt = 1'b0;
        if (wake_lvl && supply_lvl) begin
          mode_nxt = m_waking; // RULE_02
        end
      end
      m_waking: begin
        if (wake_done) begin
          mode_nxt = m_active; // RULE_01
        end
      end
      m_active, m_lowpower: begin
        if (acc_wr && (i_req.addr == MODE_CTRL_ADDR)) begin
          if (!i_req.wdata[SOFT_RESET_BIT]) begin
            ctrl_nxt = MODE_CTRL_RESET; // RULE_05
            soft_nxt = 1'b1;
            sdo_nxt = 1'b1; // RULE_06
          end else begin
            ctrl_nxt = i_req.wdata;
          end
        end
        mode_nxt = req_mode(ctrl_nxt); // RULE_10 RULE_13
      end
      m_standby: begin
        if (stby_exit) begin
          ctrl_nxt[STBY_REQ_BIT] = 1'b0;
          mode_nxt = req_mode(ctrl_nxt); // RULE_12
        end
      end
      default: begin
        mode_nxt = m_shutdown;
      end
    endcase
    if (wdt_expire) begin
      mode_nxt = m_shutdown; // RULE_08
      ctrl_nxt = MODE_CTRL_RESET;
    end
    // Reset output is held low until wake-up has completed.
    rst_oe_nxt = (mode_nxt == m_shutdown) || (mode_nxt == m_waking); // RULE_03
    ser_en_nxt = (mode_nxt == m_active) || (mode_nxt == m_lowpower);
    flags_nxt = flags_of(mode_nxt, ctrl_nxt);
    meas_nxt.cell_conv_en = (mode_nxt == m_active); // RULE_14 RULE_15
    meas_nxt.hs_conv_en = (mode_nxt == m_active); // RULE_14 RULE_15
    meas_nxt.ls_conv_allowed = (mode_nxt == m_active) ||
                               (mode_nxt == m_lowpower) ||
                               (mode_nxt == m_standby); // RULE_14
    meas_nxt.protect_en = (mode_nxt == m_active); // RULE_15
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mode_r <= m_shutdown;
      ctrl_r <= MODE_CTRL_RESET;
      rdata_r <= ZERO_WORD;
      rvalid_r <= 1'b0;
      sdo_r <= 1'b0;
      soft_r <= 1'b0;
      rst_oe_r <= 1'b1;
      rst_o_r <= 1'b0;
      ser_en_r <= 1'b0;
      flags_r <= '0;
      meas_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      sdo_r <= sdo_nxt;
      soft_r <= soft_nxt;
      rst_oe_r <= rst_oe_nxt;
      rst_o_r <= 1'b0;
      ser_en_r <= ser_en_nxt;
      flags_r <= flags_nxt;
      meas_r <= meas_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_serial_enabled = ser_en_r;
  assign o_sdo_high = sdo_r;
  assign o_soft_reset = soft_r;
  assign o_ready_reset_output_o = rst_o_r;
  assign o_ready_reset_output_oe = rst_oe_r;
  assign o_flags = flags_r;
  assign o_meas = meas_r;

endmodule

// ### opmode_chk.sv
// Port assertions for the operating-mode controller.
`timescale 1ns/1ps
module opmode_chk
  import opmode_pkg::*;
(
  input logic i_clk_sys,
  input logic i_rst_n,
  input logic i_wake_input,
  input logic i_serial_enable_pin,
  input logic i_supply_ok,
  input logic i_wdt_enable,
  input opmode_pkg::reg_req_s i_req,
  input logic [opmode_pkg::DATA_W-1:0] o_rdata,
  input logic o_rvalid,
  input logic o_serial_enabled,
  input logic o_sdo_high,
  input logic o_soft_reset,
  input logic o_ready_reset_output_o,
  input logic o_ready_reset_output_oe,
  input opmode_pkg::mode_flags_s o_flags,
  input opmode_pkg::meas_en_s o_meas
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  sequence ctrl_wr;
    o_flags.active_flag && i_req.wr && i_req.addr == 8'h01;
  endsequence
  sequence rd_ok;
    o_serial_enabled && i_req.rd && !i_req.wr;
  endsequence
  a_read_answer: assert property (rd_ok |=> o_rvalid)
    else $error("read not answered");
  a_status_read: assert property (
    rd_ok ##0 i_req.addr == 8'h1C |=> o_rdata[4:0] == $past(o_flags))
    else $error("status readback wrong");
  a_standby_mute: assert property (
    !o_serial_enabled && i_req.rd |=> !o_rvalid)
    else $error("read answered while muted");
  a_mode_comm: assert property (
    (o_flags.standby_flag |-> !o_serial_enabled) and
    (o_flags.lowpower_flag |-> o_serial_enabled))
    else $error("serial enable does not match mode");
  a_soft_reset: assert property (
    ctrl_wr ##0 !i_req.wdata[0] |=> o_soft_reset && o_sdo_high)
    else $error("soft reset not taken");
  a_lp_entry: assert property (
    ctrl_wr ##0 i_req.wdata[4:0] == 5'h09 |=> o_flags.lowpower_flag)
    else $error("low power not entered");
  a_stby_entry: assert property (
    ctrl_wr ##0 i_req.wdata[4] && i_req.wdata[0] |=> o_flags.standby_flag)
    else $error("standby not entered");
  a_reduced_meas: assert property (
    o_flags.lowpower_flag || o_flags.standby_flag
    |-> !o_meas.cell_conv_en && !o_meas.hs_conv_en)
    else $error("conversion running in reduced mode");
  a_active_meas: assert property (
    o_flags.active_flag |-> o_meas == 4'hF)
    else $error("active mode lacks a function");
  a_ready_rise: assert property (
    $fell(o_ready_reset_output_oe) |-> o_flags.active_flag)
    else $error("reset released outside active");
  a_wake_up: assert property (
    (o_flags.shutdown_flag && i_wake_input && i_supply_ok) [*3]
    |-> ##[1:40] !o_ready_reset_output_oe)
    else $error("no wake from shutdown");
endmodule
bind operating_mode_controller opmode_chk opmode_chk_i (.*);

// ### host_model.sv
// Host model: supply, wake and serial enable pins and register cycles.
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk_sys,
  input wire logic i_rvalid,
  input wire logic [opmode_pkg::DATA_W-1:0] i_rdata,
  output opmode_pkg::reg_req_s o_req,
  output logic o_wake,
  output logic o_supply,
  output logic o_sen
);
  import opmode_pkg::*;
  initial begin
    o_req = '0;
    o_wake = 1'b0;
    o_supply = 1'b0;
    o_sen = 1'b0;
  end
  // Released address and data lines show the inverse of the last value.
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [15:0] d, output logic [15:0] q, output logic ok);
    @(posedge i_clk_sys);
    o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_clk_sys);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
    ok = i_rvalid;
    q = i_rdata;
  endtask
  task automatic pins(input logic wake, input logic supply);
    @(posedge i_clk_sys);
    o_wake <= wake;
    o_supply <= supply;
  endtask
  task automatic sen_hold(input int n);
    @(posedge i_clk_sys);
    o_sen <= 1'b1;
    repeat (n) @(posedge i_clk_sys);
    o_sen <= 1'b0;
  endtask
endmodule

// ### operating_mode_controller_bench.sv
// Self-checking bench for the operating-mode controller.
`timescale 1ns/1ps
module operating_mode_controller_bench;
  import opmode_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wdt_enable = 1'b0;
  logic i_wake_input, i_supply_ok, i_serial_enable_pin, ok;
  logic o_rvalid, o_serial_enabled, o_sdo_high, o_soft_reset;
  logic o_ready_reset_output_o, o_ready_reset_output_oe;
  logic [15:0] o_rdata, q;
  reg_req_s i_req;
  mode_flags_s o_flags;
  meas_en_s o_meas;
  int mismatches = 0;
  int checks = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  operating_mode_controller #(.MS_TICK_CYCLES(32'hA), .STBY_EXIT_CYC(32'h14),
    .WDT_LIMIT_MS(32'h3), .WAKE_CYCLES(32'h4)) operating_mode_controller_i (.*);
  host_model host_model_i (.i_clk_sys(i_clk_sys), .i_rvalid(o_rvalid),
    .i_rdata(o_rdata), .o_req(i_req), .o_wake(i_wake_input),
    .o_supply(i_supply_ok), .o_sen(i_serial_enable_pin));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host_model_i.xfer(1'b1, a, d, q, ok);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    host_model_i.xfer(1'b0, a, 16'h0000, q, ok);
    chk(16'(ok), 16'h0001);
    chk(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic t_wake();
    host_model_i.pins(1'b1, 1'b0);
    cyc(30);
    chk(16'(o_flags), 16'h0010);
    host_model_i.pins(1'b1, 1'b1);
    for (int n = 0; n < 60 && o_ready_reset_output_oe !== 1'b0; n++) begin
      cyc(1);
    end
    cyc(1);
    chk(16'(o_ready_reset_output_oe), 16'h0000);
    chk(16'(o_ready_reset_output_o), 16'h0000);
    chk(16'(o_flags), 16'h0001);
    chk(16'(o_meas), 16'h000F);
    host_model_i.pins(1'b0, 1'b1);
    $display("wake test done");
  endtask
  task automatic t_soft();
    chk(16'(o_sdo_high), 16'h0000);
    wr(8'h01, 16'h0000);
    chk(16'(o_sdo_high), 16'h0001);
    chk(16'(o_soft_reset), 16'h0001);
    wr(8'h01, 16'h1801);
    wr(8'h01, 16'h0000);
    rd(8'h01, 16'h0001);
    $display("soft reset test done");
  endtask
  task automatic t_lp();
    wr(8'h01, 16'h0009);
    chk(16'(o_flags), 16'h0002);
    chk(16'(o_meas), 16'h0002);
    rd(8'h1C, 16'h0002);
    wr(8'h01, 16'h1009);
    chk(16'(o_flags), 16'h000A);
    wr(8'h01, 16'h0001);
    chk(16'(o_flags), 16'h0001);
    rd(8'h55, 16'h0000);
    $display("low power test done");
  endtask
  task automatic t_stby();
    wr(8'h01, 16'h0019);
    chk(16'(o_flags), 16'h0004);
    chk(16'(o_meas), 16'h0002);
    host_model_i.xfer(1'b0, 8'h1C, 16'h0000, q, ok);
    chk(16'(ok), 16'h0000);
    host_model_i.sen_hold(15);
    cyc(10);
    chk(16'(o_flags), 16'h0004);
    host_model_i.sen_hold(30);
    cyc(8);
    chk(16'(o_flags), 16'h0002);
    wr(8'h01, 16'h0001);
    wr(8'h01, 16'h0011);
    chk(16'(o_flags), 16'h0004);
    host_model_i.sen_hold(30);
    cyc(8);
    chk(16'(o_flags), 16'h0001);
    $display("standby test done");
  endtask
  task automatic t_wdt();
    @(posedge i_clk_sys);
    i_wdt_enable <= 1'b1;
    cyc(15);
    chk(16'(o_flags), 16'h0001);
    for (int n = 0; n < 80 && o_ready_reset_output_oe !== 1'b1; n++) begin
      cyc(1);
    end
    cyc(1);
    chk(16'(o_flags), 16'h0010);
    chk(16'(o_ready_reset_output_oe), 16'h0001);
    $display("watchdog test done");
  endtask
  // The whole sequence needs about 220 cycles; this bound is far above it.
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_wake();
    t_soft();
    t_lp();
    t_stby();
    t_wdt();
    summarize();
  end
endmodule
